// ---- src/sfp_port.sv ----
// Serial flash program port: shifter, command decode and status byte.
module sfp_port (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Serial link
	input sfp_pkg::sfp_link_in_type link_in,
	output sfp_pkg::sfp_link_out_type link_out,
	// Flash context
	input wire logic flash_blank,
	input wire logic [55:0] stored_id,
	input wire logic erase_fail,
	input wire logic program_fail,
	// Byte stream and identity status to the system
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic id_ok
);
	import sfp_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TX = 3'b010,
		ST_OP = 3'b100
	} sfp_state_type;

	// ==========================================================
	// Input synchronisers
	logic sclk_s;
	logic rxd_s;

	// Link clock crossing
	// synchronised inputs
	// The clock path resets to its idle level so no false edge follows reset.
	sfp_sync #(.RST_LEVEL(SFP_SCLK_IDLE)) u_sync_clk (
		.mclk(mclk),
		.reset_n(reset_n),
		.din(link_in.sclk),
		.dout(sclk_s)
	);
	sfp_sync u_sync_rxd (
		.mclk(mclk),
		.reset_n(reset_n),
		.din(link_in.rxd),
		.dout(rxd_s)
	);

	// ==========================================================
	// State
	logic sclk_q, sclk_d;
	logic [7:0] sh_q, sh_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] tx_q, tx_d;
	logic txd_q, txd_d;
	logic busy_q, busy_d;
	logic [7:0] stat_q, stat_d;
	logic [7:0] cmd_q, cmd_d;
	logic [3:0] idx_q, idx_d;
	logic idok_q, idok_d;
	logic idbad_q, idbad_d;
	logic [6:0] opc_q, opc_d;
	logic opprog_q, opprog_d;
	logic [7:0] rxb_q, rxb_d;
	logic rxv_q, rxv_d;
	sfp_state_type st_q, st_d;
	logic rise;
	logic fall;
	logic done;
	logic [7:0] byte_in;

	assign rise = sclk_s & ~sclk_q;
	assign fall = ~sclk_s & sclk_q;
	assign byte_in = {rxd_s, sh_q[7:1]};
	assign done = rise && cnt_q == 3'(SFP_BITS - 1);

	always_comb begin
		sclk_d = sclk_s;
		sh_d = sh_q;
		cnt_d = cnt_q;
		tx_d = tx_q;
		txd_d = txd_q;
		busy_d = busy_q;
		stat_d = stat_q;
		cmd_d = cmd_q;
		idx_d = idx_q;
		idok_d = idok_q;
		idbad_d = idbad_q;
		opc_d = opc_q;
		opprog_d = opprog_q;
		rxb_d = rxb_q;
		rxv_d = 1'b0;
		st_d = st_q;
		if (rise) begin
			sh_d = byte_in;
			cnt_d = cnt_q + 3'd1;
			busy_d = 1'b1;
		end
		if (fall && st_q == ST_TX) begin
			txd_d = tx_q[0];
			tx_d = {1'b0, tx_q[7:1]};
		end
		unique case (st_q)
			ST_IDLE: begin
				if (done) begin
					rxb_d = byte_in;
					rxv_d = 1'b1;
					busy_d = 1'b0;
					if (idx_q == 4'd0) begin
						cmd_d = byte_in;
						idx_d = 4'd1;
						if (byte_in == SFP_CMD_STATUS) begin
							// Bit 0 stands at once and each fall then
							// presents the bit that the next rise samples.
							tx_d = stat_q;
							txd_d = stat_q[0];
							st_d = ST_TX;
							busy_d = 1'b0;
							idx_d = 4'd0;
						end else if (!idok_q && !flash_blank &&
							byte_in != SFP_CMD_IDCHK) begin
							stat_d[SFP_ERS_BIT] = 1'b1;
							stat_d[SFP_PRG_BIT] = 1'b1;
							idx_d = 4'd0;
						end else if (byte_in == SFP_CMD_CLEAR) begin
							stat_d[SFP_ERS_BIT] = 1'b0;
							stat_d[SFP_PRG_BIT] = 1'b0;
							idx_d = 4'd0;
						end else if (byte_in == SFP_CMD_PROG) begin
							stat_d[SFP_RDY_BIT] = 1'b0;
							opprog_d = 1'b1;
							opc_d = 7'(SFP_OP_CYCLES - 1);
							st_d = ST_OP;
							busy_d = 1'b1;
							idx_d = 4'd0;
						end else if (byte_in != SFP_CMD_ERASE &&
							byte_in != SFP_CMD_IDCHK) begin
							idx_d = 4'd0;
						end
						idbad_d = 1'b0;
					end else if (cmd_q == SFP_CMD_ERASE) begin
						idx_d = 4'd0;
						if (byte_in == SFP_CONFIRM) begin
							stat_d[SFP_RDY_BIT] = 1'b0;
							opprog_d = 1'b0;
							opc_d = 7'(SFP_OP_CYCLES - 1);
							st_d = ST_OP;
							busy_d = 1'b1;
						end
					end else begin
						// Identity check: four header bytes, then seven.
						if (idx_q > 4'(SFP_ID_HDR) &&
							byte_in != stored_id[8*(idx_q-4'd5) +: 8])
							idbad_d = 1'b1;
						idx_d = idx_q + 4'd1;
						if (idx_q == 4'(SFP_ID_HDR + SFP_ID_LEN)) begin
							idx_d = 4'd0;
							idok_d = !(idbad_q || byte_in !=
								stored_id[55:48]);
						end
					end
				end
			end
			ST_TX: begin
				if (done) begin
					st_d = ST_IDLE;
					busy_d = 1'b0;
				end
			end
			ST_OP: begin
				busy_d = 1'b1;
				opc_d = opc_q - 7'd1;
				if (opc_q == 7'd0) begin
					stat_d[SFP_RDY_BIT] = 1'b1;
					if (opprog_q && program_fail)
						stat_d[SFP_PRG_BIT] = 1'b1;
					if (!opprog_q && erase_fail)
						stat_d[SFP_ERS_BIT] = 1'b1;
					st_d = ST_IDLE;
					busy_d = 1'b0;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sclk_q <= SFP_SCLK_IDLE;
			sh_q <= 8'h00;
			cnt_q <= 3'd0;
			tx_q <= 8'h00;
			txd_q <= 1'b1;
			busy_q <= 1'b0;
			stat_q <= SFP_STATUS_RST;
			cmd_q <= 8'h00;
			idx_q <= 4'd0;
			idok_q <= 1'b0;
			idbad_q <= 1'b0;
			opc_q <= 7'd0;
			opprog_q <= 1'b0;
			rxb_q <= 8'h00;
			rxv_q <= 1'b0;
			st_q <= ST_IDLE;
		end else begin
			sclk_q <= sclk_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			tx_q <= tx_d;
			txd_q <= txd_d;
			busy_q <= busy_d;
			stat_q <= stat_d;
			cmd_q <= cmd_d;
			idx_q <= idx_d;
			idok_q <= idok_d;
			idbad_q <= idbad_d;
			opc_q <= opc_d;
			opprog_q <= opprog_d;
			rxb_q <= rxb_d;
			rxv_q <= rxv_d;
			st_q <= st_d;
		end
	end

	assign link_out = '{txd: txd_q, busy: busy_q};
	assign rx_byte = rxb_q;
	assign rx_valid = rxv_q;
	assign id_ok = idok_q;

	// ==========================================================
	// Assertions
	busy_on_rise_a: assert property (@(posedge mclk) disable iff (!reset_n)
		rise && !done |=> busy_q) else $error("busy not raised on bit");
	busy_in_op_a: assert property (@(posedge mclk) disable iff (!reset_n)
		st_q == ST_OP |-> ##1 (busy_q || st_q == ST_IDLE))
		else $error("busy low during operation");
	tx_on_fall_a: assert property (@(posedge mclk) disable iff (!reset_n)
		!fall && !(rise && st_q == ST_IDLE) |=> $stable(txd_q))
		else $error("transmit changed off falling edge");
	rdy_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
		st_q == ST_OP |-> !stat_q[SFP_RDY_BIT])
		else $error("ready flag set during operation");
	byte_lsb_a: assert property (@(posedge mclk) disable iff (!reset_n)
		rise |=> sh_q[7] == $past(rxd_s)) else $error("bit order wrong");
	cmd_lock_a: assert property (@(posedge mclk) disable iff (!reset_n)
		done && st_q == ST_IDLE && idx_q == 4'd0 && !idok_q && !flash_blank
		&& byte_in == SFP_CMD_PROG |=> st_q != ST_OP)
		else $error("command accepted while locked");
	op_len_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(st_q == ST_OP) |-> ##64 st_q == ST_IDLE)
		else $error("operation length wrong");
	status_tx_a: assert property (@(posedge mclk) disable iff (!reset_n)
		done && st_q == ST_IDLE && idx_q == 4'd0 && byte_in == SFP_CMD_STATUS
		|=> st_q == ST_TX && txd_q == $past(stat_q[0]))
		else $error("status not returned");
	cv_status_c: cover property (@(posedge mclk) st_q == ST_TX);
	cv_op_c: cover property (@(posedge mclk) st_q == ST_OP);
	cv_idok_c: cover property (@(posedge mclk) $rose(idok_q));
endmodule // sfp_port

// ---- src/sfp_pkg.sv ----
// Package of constants and types for the serial flash program port.
// Overview of operation
// - The link is four wires: transfer clock in, receive in, transmit out and busy out.
// - Receive bits are sampled on each rising edge of the transfer clock.
// - Transmit bits change on each falling edge of the transfer clock, except status bit 0, set at the rise ending read status.
// - Every transfer is a whole eight-bit byte, least significant bit first.
// - Busy stays high while receiving, transmitting or running an operation.
// - The read status command returns the status byte of flash state and errors.
// - Busy goes low when ready for a byte and high once its reception begins.
// - Status bit 7 is sequencer ready, bit 5 erase error, bit 4 program error.
// - With flash not blank, commands other than read status and identity check are refused until the identity code matches.
package sfp_pkg;

	// ==========================================================
	// Constants
	localparam int SFP_BITS = 8;
	localparam logic [7:0] SFP_CMD_STATUS = 8'h70;
	localparam logic [7:0] SFP_CMD_CLEAR = 8'h50;
	localparam logic [7:0] SFP_CMD_IDCHK = 8'hF5;
	localparam logic [7:0] SFP_CMD_PROG = 8'h41;
	localparam logic [7:0] SFP_CMD_ERASE = 8'hA7;
	localparam logic [7:0] SFP_CONFIRM = 8'hD0;
	localparam int SFP_RDY_BIT = 7;
	localparam int SFP_ERS_BIT = 5;
	localparam int SFP_PRG_BIT = 4;
	localparam logic [7:0] SFP_STATUS_RST = 8'h80;
	localparam logic SFP_SCLK_IDLE = 1'b1;
	localparam int SFP_ID_LEN = 7;
	localparam int SFP_ID_HDR = 4;
	localparam int SFP_OP_CYCLES = 64;

	// ==========================================================
	// Types
	typedef struct packed {
		logic sclk;
		logic rxd;
	} sfp_link_in_type;

	typedef struct packed {
		logic txd;
		logic busy;
	} sfp_link_out_type;

endpackage

// ---- src/sfp_sync.sv ----
// Two-flop synchroniser for one level from outside the clock domain.
module sfp_sync #(
	parameter logic RST_LEVEL = 1'b0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Level
	input wire logic din,
	output logic dout
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = din;
		sync_d = meta_q;
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			meta_q <= RST_LEVEL;
			sync_q <= RST_LEVEL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;
endmodule // sfp_sync

// ---- tb/sfp_prog.sv ----
// Behavioural flash programmer that clocks bytes over the serial link.
module sfp_prog (
	// Serial link
	output sfp_pkg::sfp_link_in_type link_in,
	input sfp_pkg::sfp_link_out_type link_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import sfp_pkg::*;

	// ==========================================================
	// Byte transfer
	initial link_in = '{sclk: 1'b1, rxd: 1'b1};

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		int n;
		n = 0;
		while (link_out.busy !== 1'b0 && n < 3000) begin
			#20;
			n++;
		end
		for (int i = 0; i < 8; i++) begin
			link_in.sclk = 1'b0;
			link_in.rxd = tx[i];
			#80;
			link_in.sclk = 1'b1;
			#80;
			rx[i] = link_out.txd;
		end
		// The released line shows the inverse so a stale bit never passes.
		link_in.rxd = ~tx[7];
		// One system clock passes so the next byte never redrives rxd at once.
		#20;
	endtask
endmodule // sfp_prog

// ---- tb/testbench.sv ----
// Self-checking bench for the serial flash program port.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import sfp_pkg::*;

	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic flash_blank = 1'b1;
	logic [55:0] stored_id = 56'h11_2233_4455_6677;
	logic erase_fail = 1'b0;
	logic program_fail = 1'b0;
	sfp_link_in_type link_in;
	sfp_link_out_type link_out;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic id_ok;
	logic [7:0] got;
	int fail_count = 0;
	int num_checks = 0;
	int pulses = 0;

	sfp_port i_dut (.mclk(mclk), .reset_n(reset_n), .link_in(link_in),
		.link_out(link_out), .flash_blank(flash_blank),
		.stored_id(stored_id), .erase_fail(erase_fail),
		.program_fail(program_fail), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .id_ok(id_ok));
	sfp_prog i_prog (.link_in(link_in), .link_out(link_out));

	initial forever #10 mclk = ~mclk;
	always @(posedge mclk) if (rx_valid === 1'b1) pulses++;

	// ==========================================================
	// Helpers
	task automatic chk(input logic [7:0] act, input logic [7:0] exp);
		num_checks++;
		if (act !== exp) begin
			fail_count++;
			$display("MISMATCH %0t got %h want %h", $time, act, exp);
		end
	endtask

	task automatic stop_test();
		if (fail_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic send(input logic [7:0] b);
		i_prog.xfer(b, got);
	endtask

	task automatic settle();
		for (int n = 0; n < 200 && link_out.busy !== 1'b0; n++)
			@(posedge mclk);
		repeat (2) @(posedge mclk);
		#1;
		chk({7'h00, link_out.busy}, 8'h00);
	endtask

	task automatic status(input logic [7:0] exp);
		send(SFP_CMD_STATUS);
		i_prog.xfer(8'h00, got);
		chk(got, exp);
	endtask

	task automatic send_id(input logic [55:0] id);
		send(SFP_CMD_IDCHK);
		repeat (3) send(8'h00);
		send(8'(SFP_ID_LEN));
		for (int k = 0; k < SFP_ID_LEN; k++)
			send(id[8*k+:8]);
		settle();
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk({5'h00, link_out.txd, link_out.busy, id_ok}, 8'h04);
	endtask

	task automatic t_rx();
		fork
			send(SFP_CMD_CLEAR);
			begin
				#400;
				chk({7'h00, link_out.busy}, 8'h01);
			end
		join
		settle();
		chk(rx_byte, SFP_CMD_CLEAR);
		chk(pulses[7:0], 8'h01);
		status(SFP_STATUS_RST);
	endtask

	task automatic t_ops();
		program_fail = 1'b1;
		send(SFP_CMD_PROG);
		repeat (12) @(posedge mclk);
		#1;
		chk({7'h00, link_out.busy}, 8'h01);
		status(8'h90);
		program_fail = 1'b0;
		send(SFP_CMD_CLEAR);
		erase_fail = 1'b1;
		send(SFP_CMD_ERASE);
		send(SFP_CONFIRM);
		status(8'hA0);
		erase_fail = 1'b0;
		send(SFP_CMD_CLEAR);
		status(SFP_STATUS_RST);
	endtask

	task automatic t_lock();
		flash_blank = 1'b0;
		send(SFP_CMD_PROG);
		status(8'hB0);
		send(SFP_CMD_CLEAR);
		status(8'hB0);
		send_id(stored_id ^ 56'h00_0000_0000_0100);
		chk({7'h00, id_ok}, 8'h00);
		send_id(stored_id);
		chk({7'h00, id_ok}, 8'h01);
		send(SFP_CMD_CLEAR);
		status(SFP_STATUS_RST);
	endtask

	// ==========================================================
	// Sequence
	initial begin
		repeat (20) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		t_reset();
		t_rx();
		t_ops();
		t_lock();
		stop_test();
	end

	initial begin
		#1_000_000;
		fail_count++;
		stop_test();
	end
endmodule // testbench
